/* common/sas_defines.svh */
// Register indices, field positions, reset values and timing counts
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

`define SAS_ADDR_W 10
`define SAS_IDX_PWR 8'h64
`define SAS_IDX_RES_LO 8'h78
`define SAS_IDX_RES_HI 8'h79
`define SAS_IDX_CTL_A 8'h7A
`define SAS_IDX_CTL_B 8'h7B
`define SAS_IDX_MUX 8'h7C

`define SAS_CA_FLAG 4
`define SAS_CA_START 6
`define SAS_CA_EN 7
`define SAS_MX_CH_LSB 0
`define SAS_MX_LEFT 5
`define SAS_MX_REF_LSB 6
`define SAS_CB_TS_LSB 0
`define SAS_PR_BIT 0

`define SAS_RST_CTL_A 8'h00
`define SAS_RST_CTL_B 3'h0
`define SAS_RST_MUX 8'h00
`define SAS_RST_PWR 1'b1

`define SAS_TS_OWN_FLAG 3'h0
`define SAS_SYNC_STAGES 3
`define SAS_NORM_CYC_X2 6'd26
`define SAS_FIRST_CYC_X2 6'd50
`define SAS_AUTO_CYC_X2 6'd27
`define SAS_NORM_SH_X2 6'd3
`define SAS_FIRST_SH_X2 6'd27
`define SAS_AUTO_SH_X2 6'd4

`endif

/* common/sas_pkg.sv */
// Types shared by the converter sequencer
package sas_pkg;

    typedef struct packed {
        logic enable;
        logic start;
        logic auto_trig;
        logic flag;
        logic irq_en;
        logic [2:0] psel;
    } sas_ctl_a_t;

    typedef struct packed {
        logic [1:0] ref_sel;
        logic [3:0] chan;
    } sas_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PEND,
        ST_CONV
    } sas_state_t;

endpackage

/* rtl/sas_top.sv */
// Sequencer for a 10-bit successive-approximation converter
// ==========================================================
// Behaviour
// - 10-bit result in two bytes, right aligned, left aligned on demand.
// - Low byte read locks results until high byte read; late result lost.
// - High byte read unlocks result register updates.
// - Completion flag set at every conversion end, even if discarded.
// - Clear power reduction, write start; start bit high until done.
// - Channel change mid-conversion applies only after it completes.
// - Auto-trigger rising edge resets prescaler and starts a conversion.
// - Held-high trigger does not restart; edges while converting ignored.
// - Trigger source flags must be cleared by software before retrigger.
// - Own flag as trigger gives free running, flag cleared or not.
// - Software start works in auto mode; start reads one while busy.
// - Prescaler divides by selected ratio, held reset while disabled.
// - Software start begins at next converter clock rising edge.
// - Normal conversion 13 cycles, first after enable 25 cycles unless auto-triggered.
// - Sample-and-hold at 1.5 cycles, or 13.5 on a first conversion not auto-triggered.
// - Completion writes result, sets flag, clears start in single mode.
// - Auto-triggered: sample at 2 cycles, conversion 13.5 cycles.
// - Free running restarts at once; start bit stays high.
// - Channel and reference selections take effect only when enabled.
// - Channel field routes any input, ground or bandgap to converter.
// - Reference bits pick external pin, supply or internal reference.
// - Trigger select sits in control register B at 0x7B, reset zero.
// - Selection buffer tracks until start, relocks until last cycle.
`include "sas_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sas_top (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [`SAS_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [7:0] trigger_in,
    input wire logic [9:0] sar_result,
    output logic sample_hold,
    output logic conv_active,
    output sas_pkg::sas_sel_t conv_sel,
    output logic irq
);

    // ==========================================================
    // Functions
    function automatic logic [6:0] presc_last(input logic [2:0] sel);
        logic [7:0] ratio;
        ratio = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
        presc_last = 7'(ratio - 8'h01);
    endfunction

    function automatic logic [15:0] align_res(input logic [9:0] r,
                                              input logic left);
        align_res = left ? {r, 6'h00} : {6'h00, r};
    endfunction

    // ==========================================================
    // State
    sas_pkg::sas_ctl_a_t ctl_a_r;
    logic [2:0] ts_r;
    logic [7:0] mux_r;
    logic pr_r;
    logic [9:0] res_r;
    logic lock_r;
    logic first_r;
    logic auto_conv_r;
    logic [5:0] half_r;
    logic [6:0] presc_r;
    logic [`SAS_SYNC_STAGES-1:0] trig_sh_r;
    logic ack_r;
    logic [31:0] readdata_r;
    logic sample_r;
    sas_pkg::sas_sel_t sel_r;
    sas_pkg::sas_state_t state_r;
    sas_pkg::sas_state_t state_nxt;
    logic [5:0] half_nxt;
    logic auto_conv_nxt;

    // ==========================================================
    // Bus decode
    wire req = read | write;
    wire acc = req & ack_r;
    wire [7:0] idx = address[`SAS_ADDR_W-1:2];
    wire hit_lo = (idx == `SAS_IDX_RES_LO);
    wire hit_hi = (idx == `SAS_IDX_RES_HI);
    wire hit_ca = (idx == `SAS_IDX_CTL_A);
    wire hit_cb = (idx == `SAS_IDX_CTL_B);
    wire hit_mx = (idx == `SAS_IDX_MUX);
    wire hit_pr = (idx == `SAS_IDX_PWR);
    wire wr_ca = acc & write & hit_ca;
    wire wr_cb = acc & write & hit_cb;
    wire wr_mx = acc & write & hit_mx;
    wire wr_pr = acc & write & hit_pr;
    wire rd_lo = acc & read & hit_lo;
    wire rd_hi = acc & read & hit_hi;
    wire [7:0] wd = writedata[7:0];
    wire sas_pkg::sas_ctl_a_t wd_ca = wd;

    // ==========================================================
    // Prescaler and converter clock enables
    wire en = ctl_a_r.enable;
    wire [6:0] last = presc_last(ctl_a_r.psel);
    wire tick = en & (presc_r == last);
    wire half = en & (presc_r == (last >> 1));
    wire evt = tick | half;

    // ==========================================================
    // Trigger edge and conversion timing
    wire trig_edge = trig_sh_r[1] & ~trig_sh_r[2];
    wire free_run = ctl_a_r.auto_trig & (ts_r == `SAS_TS_OWN_FLAG);
    wire trig_fire = trig_edge & en & ctl_a_r.auto_trig
                     & (ts_r != `SAS_TS_OWN_FLAG)
                     & (state_r == sas_pkg::ST_IDLE);
    wire sw_start = wr_ca & wd_ca.start & wd_ca.enable & en & ~pr_r
                    & (state_r == sas_pkg::ST_IDLE);
    wire [5:0] len_x2 = auto_conv_r ? `SAS_AUTO_CYC_X2 :
                        first_r ? `SAS_FIRST_CYC_X2 : `SAS_NORM_CYC_X2;
    wire [5:0] sh_x2 = auto_conv_r ? `SAS_AUTO_SH_X2 :
                       first_r ? `SAS_FIRST_SH_X2 : `SAS_NORM_SH_X2;
    wire [5:0] half_inc = 6'(half_r + 6'd1);
    wire in_conv = (state_r == sas_pkg::ST_CONV);
    wire complete = in_conv & evt & (half_inc == len_x2);
    wire sample_fire = in_conv & evt & (half_inc == sh_x2);
    wire last_cyc = half_r >= 6'(len_x2 - 6'd2);
    wire sel_track = en & (~in_conv | last_cyc);
    wire [15:0] res_al = align_res(res_r, mux_r[`SAS_MX_LEFT]);
    wire start_bit = (state_r != sas_pkg::ST_IDLE);

    // ==========================================================
    // Read data
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        if (hit_lo)
            rd_byte = res_al[7:0];
        else if (hit_hi)
            rd_byte = res_al[15:8];
        else if (hit_ca)
            rd_byte = {ctl_a_r.enable, start_bit, ctl_a_r[5:0]};
        else if (hit_cb)
            rd_byte = {5'h00, ts_r};
        else if (hit_mx)
            rd_byte = mux_r;
        else if (hit_pr)
            rd_byte = {7'h00, pr_r};
    end

    // ==========================================================
    // Sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        half_nxt = half_r;
        auto_conv_nxt = auto_conv_r;
        unique case (state_r)
            sas_pkg::ST_IDLE:
            begin
                if (trig_fire)
                begin
                    state_nxt = sas_pkg::ST_CONV;
                    half_nxt = 6'd0;
                    auto_conv_nxt = 1'b1;
                end
                else if (sw_start)
                    state_nxt = sas_pkg::ST_PEND;
            end
            sas_pkg::ST_PEND:
            begin
                if (tick)
                begin
                    state_nxt = sas_pkg::ST_CONV;
                    half_nxt = 6'd0;
                    auto_conv_nxt = 1'b0;
                end
            end
            sas_pkg::ST_CONV:
            begin
                if (complete & free_run)
                begin
                    half_nxt = 6'd0;
                    auto_conv_nxt = 1'b0;
                end
                else if (complete)
                    state_nxt = sas_pkg::ST_IDLE;
                else if (evt)
                    half_nxt = half_inc;
            end
        endcase
        if (!en)
            state_nxt = sas_pkg::ST_IDLE;
    end

    // ==========================================================
    // Bus slave
    always_ff @(posedge core_clk)
    begin
        if (srst)
            ack_r <= 1'b0;
        else
            ack_r <= req & ~ack_r;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            readdata_r <= 32'h0000_0000;
        else if (req & ~ack_r)
            readdata_r <= {24'h00_0000, rd_byte};
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ctl_a_r <= `SAS_RST_CTL_A;
            ts_r <= `SAS_RST_CTL_B;
            mux_r <= `SAS_RST_MUX;
            pr_r <= `SAS_RST_PWR;
        end
        else
        begin
            if (wr_ca)
            begin
                ctl_a_r.enable <= wd_ca.enable;
                ctl_a_r.auto_trig <= wd_ca.auto_trig;
                ctl_a_r.irq_en <= wd_ca.irq_en;
                ctl_a_r.psel <= wd_ca.psel;
            end
            if (complete)
                ctl_a_r.flag <= 1'b1;
            else if (wr_ca & wd_ca.flag)
                ctl_a_r.flag <= 1'b0;
            ctl_a_r.start <= 1'b0;
            if (wr_cb)
                ts_r <= wd[`SAS_CB_TS_LSB +: 3];
            if (wr_mx)
                mux_r <= wd;
            if (wr_pr)
                pr_r <= wd[`SAS_PR_BIT];
        end
    end

    // ==========================================================
    // Prescaler and trigger synchroniser
    always_ff @(posedge core_clk)
    begin
        if (srst | ~en | trig_fire)
            presc_r <= 7'h00;
        else
            presc_r <= tick ? 7'h00 : 7'(presc_r + 7'h01);
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            trig_sh_r <= '0;
        else
            trig_sh_r <= {trig_sh_r[1:0], trigger_in[ts_r]};
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_r <= sas_pkg::ST_IDLE;
            half_r <= 6'd0;
            auto_conv_r <= 1'b0;
            first_r <= 1'b1;
            sample_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            half_r <= half_nxt;
            auto_conv_r <= auto_conv_nxt;
            sample_r <= sample_fire;
            if (!en)
                first_r <= 1'b1;
            else if (complete)
                first_r <= 1'b0;
        end
    end

    // ==========================================================
    // Result registers and read lock
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            res_r <= 10'h000;
            lock_r <= 1'b0;
        end
        else
        begin
            if (complete & ~lock_r)
                res_r <= sar_result;
            if (rd_lo)
                lock_r <= 1'b1;
            else if (rd_hi)
                lock_r <= 1'b0;
        end
    end

    // ==========================================================
    // Channel and reference buffer
    always_ff @(posedge core_clk)
    begin
        if (srst)
            sel_r <= '0;
        else if (sel_track)
        begin
            sel_r.ref_sel <= mux_r[`SAS_MX_REF_LSB +: 2];
            sel_r.chan <= mux_r[`SAS_MX_CH_LSB +: 4];
        end
    end

    // ==========================================================
    // Outputs
    assign waitrequest = req & ~ack_r;
    assign readdata = readdata_r;
    assign sample_hold = sample_r;
    assign conv_active = in_conv;
    assign conv_sel = sel_r;
    assign irq = ctl_a_r.flag & ctl_a_r.irq_en;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_high_read;
        acc && read && hit_hi;
    endsequence

    property p_flag_set;
        complete |=> ctl_a_r.flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set after completion");

    property p_lock_hold;
        lock_r && complete |=> $stable(res_r);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked result was overwritten");

    property p_unlock;
        s_high_read |=> !lock_r;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("high byte read did not unlock");

    property p_single_done;
        complete && !free_run |=> !start_bit && !conv_active;
    endproperty
    a_single_done: assert property (p_single_done)
        else $error("start bit still high after single conversion");

    property p_free_run;
        complete && free_run && en |=> conv_active && start_bit
                                       && half_r == 6'd0;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("free running did not restart");

    property p_presc_off;
        !en |=> presc_r == 7'h00 && !tick;
    endproperty
    a_presc_off: assert property (p_presc_off)
        else $error("prescaler ran while disabled");

    property p_pend_start;
        state_r == sas_pkg::ST_PEND && tick && en |=>
            in_conv ##0 half_r == 6'd0;
    endproperty
    a_pend_start: assert property (p_pend_start)
        else $error("pending start missed converter clock edge");

    property p_sel_lock;
        in_conv && !last_cyc && !complete |=> $stable(sel_r);
    endproperty
    a_sel_lock: assert property (p_sel_lock)
        else $error("selection changed during conversion");

    property p_norm_len;
        complete && !auto_conv_r && !first_r |-> half_r == 6'd25 && tick;
    endproperty
    a_norm_len: assert property (p_norm_len)
        else $error("normal conversion length wrong");

    property p_irq;
        (complete || ctl_a_r.flag) && ctl_a_r.irq_en && !wr_ca |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing with flag and enable set");

endmodule

`default_nettype wire

/* test/sas_conv_model.sv */
// Behavioural model of the analog converter behind the sequencer
`timescale 1ns/1ps
`default_nettype none

module sas_conv_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic sample_hold,
    input wire sas_pkg::sas_sel_t conv_sel,
    output logic [9:0] sar_result
);
    // ==========================================================
    // Sampled value encodes the routed channel and reference
    always_ff @(posedge core_clk)
    begin
        if (srst)
            sar_result <= 10'h000;
        else if (sample_hold)
            sar_result <= {conv_sel.chan, conv_sel.ref_sel, 4'h5};
    end
endmodule

`default_nettype wire

/* test/sas_top_tb.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end

module sas_top_tb;
    // ==========================================================
    // Signals
    logic core_clk = 1'b0;
    logic srst;
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic [7:0] trigger_in;
    logic [9:0] sar_result;
    logic sample_hold;
    logic conv_active;
    logic irq;
    sas_pkg::sas_sel_t conv_sel;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    int cur = 0;
    int sh_at = 0;
    int last_len = 0;
    int last_sh = 0;
    int n_sh = 0;
    int f_len;
    int f_sh;
    int n_len;
    int n_sha;
    int b;
    logic [7:0] d;

    // ==========================================================
    // Design and converter model
    sas_top u_dut (
        .core_clk(core_clk),
        .srst(srst),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .trigger_in(trigger_in),
        .sar_result(sar_result),
        .sample_hold(sample_hold),
        .conv_active(conv_active),
        .conv_sel(conv_sel),
        .irq(irq)
    );

    sas_conv_model u_model (
        .core_clk(core_clk),
        .srst(srst),
        .sample_hold(sample_hold),
        .conv_sel(conv_sel),
        .sar_result(sar_result)
    );

    // ==========================================================
    // Clock, conversion monitor and timeout
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (sample_hold === 1'b1)
            n_sh <= n_sh + 1;
        if (conv_active === 1'b1)
        begin
            cur <= cur + 1;
            if (sample_hold === 1'b1)
                sh_at <= cur;
        end
        else if (cur != 0)
        begin
            last_len <= cur;
            last_sh <= sh_at;
            cur <= 0;
        end
        if (cyc == 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    // ==========================================================
    // Tasks
    task automatic bus_acc(input logic wr_en, input logic [7:0] idx,
                           input logic [7:0] v);
        begin
            @(posedge core_clk);
            address <= {idx, 2'b00};
            writedata <= {24'h00_0000, v};
            write <= wr_en;
            read <= ~wr_en;
            do
            begin
                @(posedge core_clk);
            end
            while (waitrequest !== 1'b0);
            d = readdata[7:0];
            write <= 1'b0;
            read <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        bus_acc(1'b1, idx, v);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
        begin
            bus_acc(1'b0, idx, 8'h00);
            `CHK(d, e);
        end
    endtask

    task automatic wait_done();
        int n;
        logic seen;
        begin
            n = 0;
            seen = 1'b0;
            while (conv_active !== 1'b1 && n < 500)
            begin
                @(posedge core_clk);
                n++;
            end
            seen = (conv_active === 1'b1);
            while (conv_active === 1'b1 && n < 3000)
            begin
                @(posedge core_clk);
                n++;
            end
            repeat (2) @(posedge core_clk);
            `CHK(seen && n < 3000, 1'b1);
        end
    endtask

    task automatic summarize();
        begin
            $display("tests %0d failures %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // ==========================================================
    // Test sequence
    initial
    begin
        srst = 1'b1;
        address = 10'h000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        trigger_in = 8'h00;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        rd_chk(8'h7A, 8'h00);
        rd_chk(8'h7B, 8'h00);
        rd_chk(8'h7C, 8'h00);
        rd_chk(8'h64, 8'h01);
        wr(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        wr(8'h7C, 8'h43);
        repeat (4) @(posedge core_clk);
        `CHK(conv_sel, 6'h00);
        wr(8'h64, 8'h00);
        wr(8'h7A, 8'h80);
        wr(8'h7A, 8'hC0);
        rd_chk(8'h7A, 8'hC0);
        `CHK(conv_sel, 6'h13);
        wr(8'h7C, 8'h45);
        `CHK(conv_sel, 6'h13);
        wait_done();
        f_len = last_len;
        f_sh = last_sh;
        rd_chk(8'h7A, 8'h90);
        `CHK(irq, 1'b0);
        rd_chk(8'h78, 8'hD5);
        rd_chk(8'h79, 8'h00);
        wr(8'h7C, 8'h65);
        wr(8'h7A, 8'hD8);
        wait_done();
        `CHK(f_len - last_len, 24);
        `CHK(f_sh - last_sh, 24);
        n_len = last_len;
        n_sha = last_sh;
        `CHK(irq, 1'b1);
        rd_chk(8'h78, 8'h40);
        rd_chk(8'h79, 8'h55);
        wr(8'h7A, 8'h98);
        @(posedge core_clk);
        `CHK(irq, 1'b0);
        rd_chk(8'h78, 8'h40);
        wr(8'h7C, 8'h62);
        wr(8'h7A, 8'hC8);
        wait_done();
        rd_chk(8'h7A, 8'h98);
        rd_chk(8'h79, 8'h55);
        wr(8'h7A, 8'hC8);
        wait_done();
        rd_chk(8'h78, 8'h40);
        rd_chk(8'h79, 8'h25);
        wr(8'h7C, 8'h42);
        wr(8'h7A, 8'hC2);
        wait_done();
        `CHK(last_len - n_len, 26);
        rd_chk(8'h78, 8'h95);
        rd_chk(8'h79, 8'h00);
        wr(8'h7B, 8'h02);
        rd_chk(8'h7B, 8'h02);
        wr(8'h7A, 8'hB0);
        b = n_sh;
        trigger_in <= 8'h04;
        repeat (12) @(posedge core_clk);
        trigger_in <= 8'h00;
        @(posedge core_clk);
        trigger_in <= 8'h04;
        wait_done();
        `CHK(last_len - n_len, 1);
        `CHK(last_sh - n_sha, 1);
        repeat (100) @(posedge core_clk);
        `CHK(n_sh - b, 1);
        wr(8'h7A, 8'hE0);
        wait_done();
        `CHK(n_sh - b, 2);
        trigger_in <= 8'h00;
        wr(8'h7B, 8'h00);
        b = n_sh;
        wr(8'h7A, 8'hF0);
        repeat (200) @(posedge core_clk);
        rd_chk(8'h7A, 8'hF0);
        `CHK(n_sh - b >= 6, 1'b1);
        wr(8'h7A, 8'h00);
        repeat (4) @(posedge core_clk);
        `CHK(conv_active, 1'b0);
        summarize();
    end
endmodule

`default_nettype wire
